/* hw/pmv_fetch.sv */
`timescale 1ns/1ns
`include "pmv_map.svh"
// Summary of operation
// - 4096 x 8 program memory read directly by the program counter
// - addresses 000h to 00fh hold the sixteen byte vector region
// - vector byte0: bank flags bits 7,6, zeros, address bits 11..8
// - reset or interrupt loads both bank flags and 12-bit address
// - slots in order reset, btimer, ext0, ext1, serial, timer0
// - slot chosen by source position only, never by its content
// - addresses 020h to 07fh form the lookup region for table refs
// - table ref executes one two-byte or two one-byte instructions
// - table jump or call forms reach any program address
// - 010h-01fh and 080h-fffh general; small part ends at 7ffh
// - unused vector or lookup bytes fetch as ordinary code
module pmv_fetch #(
  parameter int unsigned DEPTH  = `PMV_ROM_DEPTH,
  parameter bit          SMALL  = 1'b0
) (
  // clock and reset
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_b,
  // program load port
  input  wire logic                    i_load_we,
  input  wire logic [`PMV_ADDR_W-1:0]  i_load_addr,
  input  wire logic [7:0]              i_load_data,
  // sequencing requests from the cpu
  input  wire logic                    i_irq_take,
  input  wire logic [2:0]              i_irq_src,
  input  wire logic                    i_ref_take,
  input  wire logic [5:0]              i_ref_index,
  input  wire logic                    i_pc_load,
  input  wire logic [`PMV_ADDR_W-1:0]  i_pc_value,
  input  wire logic                    i_pc_step,
  // fetch results
  output logic [`PMV_ADDR_W-1:0]       o_program_counter,
  output logic [7:0]                   o_fetch_byte,
  output logic [`PMV_ADDR_W-1:0]       o_fetch_addr,
  output logic                         o_ref_fetch,
  output logic                         o_memory_bank_enable_flag,
  output logic                         o_register_bank_enable_flag,
  output logic                         o_vector_busy,
  output logic                         o_vector_done,
  output logic                         o_ref_pair_valid,
  output logic [15:0]                  o_ref_pair
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // slots stay inside vector region
  function automatic logic [`PMV_ADDR_W-1:0] slot_addr(
    input logic [2:0] src
  );
    slot_addr = `PMV_VEC_BASE |
      (`PMV_ADDR_W'(src) << `PMV_VEC_SLOT_SHIFT);
  endfunction

  function automatic logic [`PMV_ADDR_W-1:0] ref_addr(
    input logic [5:0] idx
  );
    ref_addr = `PMV_REF_BASE + (`PMV_ADDR_W'(idx) << 1);
  endfunction

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  // rom array
  logic [7:0] rom_mem [DEPTH];
  logic [`PMV_ADDR_W-1:0] rd_addr;
  logic [`PMV_ADDR_W-1:0] addr_mask;
  assign addr_mask = SMALL ? `PMV_GEN_HI_SMALL : `PMV_GEN_HI_LAST;

  always_ff @(posedge i_ref_clk) begin
    if (i_load_we) begin
      rom_mem[i_load_addr & addr_mask] <= i_load_data;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  pmv_pkg::pmv_state_e     state_reg;
  pmv_pkg::pmv_state_e     state_next;
  logic [`PMV_ADDR_W-1:0]  pc_reg;
  logic [`PMV_ADDR_W-1:0]  ptr_reg;
  logic [7:0]              hi_reg;
  logic                    mbe_reg;
  logic                    rbe_reg;
  logic                    done_reg;
  logic                    pair_v_reg;
  logic [15:0]             pair_reg;
  logic [7:0]              byte_reg;
  logic [`PMV_ADDR_W-1:0]  faddr_reg;
  logic                    rfetch_reg;
  logic                    boot_reg;
  logic [7:0]              rd_byte;

  // any byte reads as plain code
  assign rd_byte = rom_mem[rd_addr & addr_mask];

  always_comb begin
    rd_addr = pc_reg;
    case (state_reg)
      pmv_pkg::PMV_ST_VEC0, pmv_pkg::PMV_ST_VEC1,
      pmv_pkg::PMV_ST_REF0, pmv_pkg::PMV_ST_REF1: begin
        rd_addr = ptr_reg;
      end
      default: begin
        rd_addr = pc_reg;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pmv_pkg::PMV_ST_RUN: begin
        if (boot_reg || i_irq_take) begin
          state_next = pmv_pkg::PMV_ST_VEC0;
        end else if (i_ref_take) begin
          state_next = pmv_pkg::PMV_ST_REF0;
        end
      end
      pmv_pkg::PMV_ST_VEC0: state_next = pmv_pkg::PMV_ST_VEC1;
      pmv_pkg::PMV_ST_VEC1: state_next = pmv_pkg::PMV_ST_RUN;
      pmv_pkg::PMV_ST_REF0: state_next = pmv_pkg::PMV_ST_REF1;
      pmv_pkg::PMV_ST_REF1: state_next = pmv_pkg::PMV_ST_RUN;
      default: state_next = pmv_pkg::PMV_ST_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= pmv_pkg::PMV_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // reset needs a vector fetch once released
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      boot_reg <= 1'b1;
    end else if (state_reg == pmv_pkg::PMV_ST_RUN) begin
      boot_reg <= 1'b0;
    end
  end

  // pointer into vector or lookup region
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ptr_reg <= `PMV_VEC_BASE;
    end else if (state_reg == pmv_pkg::PMV_ST_RUN) begin
      if (boot_reg) begin
        ptr_reg <= slot_addr(pmv_pkg::PMV_SRC_RESET);
      end else if (i_irq_take) begin
        ptr_reg <= slot_addr(i_irq_src);
      end else if (i_ref_take) begin
        ptr_reg <= ref_addr(i_ref_index);
      end
    end else if (state_reg == pmv_pkg::PMV_ST_VEC0 ||
                 state_reg == pmv_pkg::PMV_ST_REF0) begin
      ptr_reg <= ptr_reg + `PMV_ADDR_W'(1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_reg <= 8'h00;
    end else if (state_reg == pmv_pkg::PMV_ST_VEC0 ||
                 state_reg == pmv_pkg::PMV_ST_REF0) begin
      hi_reg <= rd_byte;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_reg  <= `PMV_VEC_BASE;
      mbe_reg <= 1'b0;
      rbe_reg <= 1'b0;
    end else if (state_reg == pmv_pkg::PMV_ST_VEC1) begin
      mbe_reg <= hi_reg[`PMV_VEC_MBE_BIT];
      rbe_reg <= hi_reg[`PMV_VEC_RBE_BIT];
      pc_reg  <= {hi_reg[`PMV_VEC_HI_MSB:0], rd_byte};
    end else if (state_reg == pmv_pkg::PMV_ST_RUN) begin
      // table jump target comes back here
      if (i_pc_load) begin
        pc_reg <= i_pc_value & addr_mask;
      end else if (i_pc_step) begin
        pc_reg <= (pc_reg + `PMV_ADDR_W'(1)) & addr_mask;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pair_reg   <= 16'h0000;
      pair_v_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      pair_v_reg <= (state_reg == pmv_pkg::PMV_ST_REF1);
      done_reg   <= (state_reg == pmv_pkg::PMV_ST_VEC1);
      if (state_reg == pmv_pkg::PMV_ST_REF1) begin
        pair_reg <= {hi_reg, rd_byte};
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      byte_reg   <= 8'h00;
      faddr_reg  <= `PMV_VEC_BASE;
      rfetch_reg <= 1'b0;
    end else begin
      byte_reg   <= rd_byte;
      faddr_reg  <= rd_addr & addr_mask;
      rfetch_reg <= (state_reg == pmv_pkg::PMV_ST_REF0 ||
                     state_reg == pmv_pkg::PMV_ST_REF1);
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_program_counter           = pc_reg;
  assign o_fetch_byte                = byte_reg;
  assign o_fetch_addr                = faddr_reg;
  assign o_ref_fetch                 = rfetch_reg;
  assign o_memory_bank_enable_flag   = mbe_reg;
  assign o_register_bank_enable_flag = rbe_reg;
  assign o_vector_busy = (state_reg != pmv_pkg::PMV_ST_RUN) || boot_reg;
  assign o_vector_done               = done_reg;
  assign o_ref_pair_valid            = pair_v_reg;
  assign o_ref_pair                  = pair_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_vec_walk;
    state_reg == pmv_pkg::PMV_ST_VEC0 ##1
    state_reg == pmv_pkg::PMV_ST_VEC1;
  endsequence

  a_vector_region: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    state_reg == pmv_pkg::PMV_ST_VEC0 |-> ptr_reg <= `PMV_VEC_LAST)
    else $error("vector read outside vector region");

  a_slot_position: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state_reg == pmv_pkg::PMV_ST_RUN && !boot_reg && i_irq_take)
    |=> ptr_reg == `PMV_ADDR_W'({$past(i_irq_src), 1'b0}) ##0 s_vec_walk)
    else $error("interrupt slot not at source position");

  a_vector_load: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    s_vec_walk |=> pc_reg[7:0] == $past(rd_byte) && done_reg &&
      mbe_reg == $past(hi_reg[`PMV_VEC_MBE_BIT]))
    else $error("vector load mismatch");

  a_ref_even: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    state_reg == pmv_pkg::PMV_ST_REF0 |->
      ptr_reg[0] == 1'b0 && ptr_reg >= `PMV_REF_BASE &&
      ptr_reg <= `PMV_REF_LAST)
    else $error("lookup address not even in region");

  a_ref_pair: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    state_reg == pmv_pkg::PMV_ST_REF0 |-> ##2 pair_v_reg)
    else $error("lookup pair not delivered");

  a_pc_target: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state_reg == pmv_pkg::PMV_ST_RUN && i_pc_load)
    |=> pc_reg == ($past(i_pc_value) & $past(addr_mask)))
    else $error("jump target not loaded into counter");

endmodule

/* common/pmv_map.svh */
`ifndef PMV_MAP_SVH
`define PMV_MAP_SVH

// ------------------------------------------------------------
// program memory map
// ------------------------------------------------------------
`define PMV_ROM_DEPTH      4096
`define PMV_ADDR_W         12
`define PMV_VEC_BASE       12'h000
`define PMV_VEC_LAST       12'h00f
`define PMV_GEN_LO_BASE    12'h010
`define PMV_GEN_LO_LAST    12'h01f
`define PMV_REF_BASE       12'h020
`define PMV_REF_LAST       12'h07f
`define PMV_GEN_HI_BASE    12'h080
`define PMV_GEN_HI_LAST    12'hfff
`define PMV_GEN_HI_SMALL   12'h7ff

// ------------------------------------------------------------
// vector entry fields, first byte
// ------------------------------------------------------------
`define PMV_VEC_MBE_BIT    7
`define PMV_VEC_RBE_BIT    6
`define PMV_VEC_HI_MSB     3
`define PMV_VEC_SLOT_SHIFT 1

`endif

/* common/pmv_pkg.sv */
package pmv_pkg;

  // vector slots in fixed order from address zero
  typedef enum logic [2:0] {
    PMV_SRC_RESET  = 3'h0,
    PMV_SRC_BTIMER = 3'h1,
    PMV_SRC_EXT0   = 3'h2,
    PMV_SRC_EXT1   = 3'h3,
    PMV_SRC_SERIAL = 3'h4,
    PMV_SRC_TIMER0 = 3'h5
  } pmv_src_e;

  // fetch sequencer states, one-hot
  typedef enum logic [4:0] {
    PMV_ST_RUN   = 5'h01,
    PMV_ST_VEC0  = 5'h02,
    PMV_ST_VEC1  = 5'h04,
    PMV_ST_REF0  = 5'h08,
    PMV_ST_REF1  = 5'h10
  } pmv_state_e;

endpackage

/* testbench/pmv_cpu_model.sv */
`timescale 1ns/1ns
module pmv_cpu_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  // status from the fetch block
  input  wire logic        i_vector_busy,
  // sequencing requests
  output logic             o_irq_take,
  output logic [2:0]       o_irq_src,
  output logic             o_ref_take,
  output logic [5:0]       o_ref_index,
  output logic             o_pc_load,
  output logic [11:0]      o_pc_value,
  output logic             o_pc_step
);
  initial begin
    o_irq_take  = 1'b0;
    o_irq_src   = 3'h0;
    o_ref_take  = 1'b0;
    o_ref_index = 6'h00;
    o_pc_load   = 1'b0;
    o_pc_value  = 12'h000;
    o_pc_step   = 1'b0;
  end

  // kind 0 vector, 1 table ref, 2 load, 3 step; called 1 ns past an edge
  // requests while busy would be dropped silently, so wait for idle
  task automatic issue(input logic [1:0] kind, input logic [11:0] val);
    int n;
    n = 0;
    while ((i_vector_busy !== 1'b0 || i_rst_b !== 1'b1) && n < 50) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    case (kind)
      2'h0: begin
        o_irq_take = 1'b1;
        o_irq_src  = val[2:0];
      end
      2'h1: begin
        o_ref_take  = 1'b1;
        o_ref_index = val[5:0];
      end
      2'h2: begin
        o_pc_load  = 1'b1;
        o_pc_value = val;
      end
      default: begin
        o_pc_step = 1'b1;
      end
    endcase
    @(posedge i_ref_clk);
    #1;
    o_irq_take = 1'b0;
    o_ref_take = 1'b0;
    o_pc_load  = 1'b0;
    o_pc_step  = 1'b0;
  endtask
endmodule

/* testbench/program_memory_vector_and_ref_map_tb_top.sv */
`timescale 1ns/1ns
module program_memory_vector_and_ref_map_tb_top;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic        we        = 1'b0;
  logic [11:0] la        = 12'h000;
  logic [7:0]  ld        = 8'h00;
  logic        irq, rtk, pld, pst, busy, done, rfv, rff, mbe, rbe;
  logic [2:0]  src;
  logic [5:0]  idx;
  logic [11:0] pv, pc, fa;
  logic [7:0]  fb;
  logic [15:0] pair;
  int          failures  = 0;
  int          num_checks = 0;
  int          cycles    = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  pmv_cpu_model cpu_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_vector_busy(busy), .o_irq_take(irq), .o_irq_src(src),
    .o_ref_take(rtk), .o_ref_index(idx), .o_pc_load(pld),
    .o_pc_value(pv), .o_pc_step(pst));

  pmv_fetch dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_load_we(we), .i_load_addr(la), .i_load_data(ld),
    .i_irq_take(irq), .i_irq_src(src), .i_ref_take(rtk),
    .i_ref_index(idx), .i_pc_load(pld), .i_pc_value(pv),
    .i_pc_step(pst), .o_program_counter(pc), .o_fetch_byte(fb),
    .o_fetch_addr(fa), .o_ref_fetch(rff),
    .o_memory_bank_enable_flag(mbe),
    .o_register_bank_enable_flag(rbe), .o_vector_busy(busy),
    .o_vector_done(done), .o_ref_pair_valid(rfv), .o_ref_pair(pair));

  // image differs per byte so a wrong slot or offset shows;
  // slot bits fold into bits 7..6 so both bank flags get exercised
  function automatic logic [7:0] img(input logic [11:0] a);
    return a[7:0] ^ {a[2:1], a[11:8], 2'h2};
  endfunction

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic wait_on(input bit ref_side);
    int n;
    n = 0;
    while ((ref_side ? rfv : done) !== 1'b1 && n < 20) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic check_vec(input logic [2:0] s);
    logic [7:0] b0, b1;
    b0 = img({8'h00, s, 1'b0});
    b1 = img({8'h00, s, 1'b1});
    wait_on(1'b0);
    cmp16({14'h0, done, busy}, 16'h0002);
    cmp16({4'h0, pc}, {4'h0, b0[3:0], b1});
    cmp16({14'h0, mbe, rbe}, {14'h0, b0[7:6]});
  endtask

  task automatic load_image();
    for (int a = 0; a < 4096; a++) begin
      la = a[11:0];
      ld = img(a[11:0]);
      we = 1'b1;
      @(posedge i_ref_clk);
      #1;
    end
    we = 1'b0;
  endtask

  task automatic test_reset();
    i_rst_b = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_rst_b = 1'b1;
    check_vec(3'h0);
  endtask

  task automatic test_irq();
    for (int s = 1; s < 6; s++) begin
      cpu_u.issue(2'h0, 12'(s));
      check_vec(s[2:0]);
    end
  endtask

  task automatic test_ref();
    int ix [4] = '{0, 1, 23, 47};
    logic [11:0] a;
    foreach (ix[i]) begin
      a = 12'h020 + 12'(2 * ix[i]);
      cpu_u.issue(2'h1, 12'(ix[i]));
      wait_on(1'b1);
      cmp16(pair, {img(a), img(a + 12'h001)});
      cmp16({2'h0, rfv, rff, fa}, {4'h3, a + 12'h001});
    end
  endtask

  // general, vector-slot and lookup bytes fetch as code
  task automatic test_jump();
    logic [11:0] t [6] = '{12'h005, 12'h010, 12'h01f, 12'h07f,
                           12'h080, 12'hfff};
    foreach (t[i]) begin
      cpu_u.issue(2'h2, t[i]);
      repeat (2) @(posedge i_ref_clk);
      #1;
      cmp16({3'h0, rff, pc}, {4'h0, t[i]});
      cmp16({4'h0, fa}, {4'h0, t[i]});
      cmp16({8'h00, fb}, {8'h00, img(t[i])});
      cpu_u.issue(2'h3, 12'h000);
      repeat (2) @(posedge i_ref_clk);
      #1;
      cmp16({4'h0, pc}, {4'h0, t[i] + 12'h001});
      cmp16({8'h00, fb}, {8'h00, img(t[i] + 12'h001)});
    end
  endtask

  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1;
    // load from release on, so the boot walk reads written bytes
    i_rst_b = 1'b1;
    load_image();
    test_reset();
    test_irq();
    test_ref();
    test_jump();
    final_report();
  end
endmodule
